// File: rtl/irq_pkg.sv
// Shared constants, types and carriers of the interrupt logic.
package irq_pkg;
	// ==========================================================
	// Register map: indices, byte address is four times the index
	// ==========================================================
	localparam logic [7:0] EXT_CTRL_IDX = 8'h0a;
	localparam logic [7:0] TCTL_IDX = 8'h0b;
	localparam int ENABLE_BIT = 7;
	localparam int PENDING_BIT = 3;
	localparam int CLEAR_BIT = 1;
	localparam int WRAP_EN_BIT = 0;
	localparam int PER_EN_BIT = 1;
	localparam int WRAP_FLAG_BIT = 4;
	localparam int PER_FLAG_BIT = 5;
	localparam int MASK_BIT = 7;
	localparam int COND_MASK_BIT = 3;
	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic ENABLE_RST = 1'b1;
	localparam logic PENDING_RST = 1'b0;
	localparam logic MASK_RST = 1'b1;
	localparam logic TIMER_EN_RST = 1'b0;
	localparam logic [5:0] SP_RST = 6'h3f;
	localparam logic [1:0] SP_PAGE = 2'h3;
	// ==========================================================
	// Vectors and stacking
	// ==========================================================
	localparam logic [15:0] VEC_TRAP = 16'h07fc;
	localparam logic [15:0] VEC_EXT = 16'h07fa;
	localparam logic [15:0] VEC_TIMER = 16'h07f8;
	localparam logic [2:0] STACK_LAST = 3'h4;
	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [2:0]
	{
		S_IDLE = 3'b000,
		S_PUSH = 3'b001,
		S_VECTOR = 3'b010,
		S_PULL = 3'b011,
		S_RESTORE = 3'b100
	} seq_state_e;
	typedef enum logic [1:0]
	{
		SRC_NONE = 2'b00,
		SRC_TRAP = 2'b01,
		SRC_EXT = 2'b10,
		SRC_TIMER = 2'b11
	} src_e;
	typedef enum logic [2:0]
	{
		SLOT_PCL = 3'b000,
		SLOT_PCH = 3'b001,
		SLOT_X = 3'b010,
		SLOT_A = 3'b011,
		SLOT_COND = 3'b100
	} stack_slot_e;
	typedef struct packed
	{
		logic [15:0] pc;
		logic [7:0] x;
		logic [7:0] a;
		logic [7:0] cond;
	} cpu_regs_s;
	typedef struct packed
	{
		logic we;
		logic re;
		logic [7:0] addr;
		logic [7:0] wdata;
		stack_slot_e slot;
	} stack_bus_s;
endpackage

// File: rtl/reset_sync.sv
// Two-stage release synchroniser for the asynchronous reset.
`timescale 1ns/1ps
module reset_sync
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	output logic o_rst_n
);
	logic stage;

	// Assert at once, release only after two clean edges.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			stage <= 1'b0;
			o_rst_n <= 1'b0;
		end
		else
		begin
			stage <= 1'b1;
			o_rst_n <= stage;
		end
	end
endmodule

// File: rtl/pin_trigger.sv
// Edge or edge-plus-level request detector for one interrupt pin.
`timescale 1ns/1ps
module pin_trigger
#(
	parameter bit ACTIVE_HIGH = 1'b0,
	parameter bit LEVEL_MODE = 1'b0
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	output logic o_req
);
	logic active;
	logic prev;

	// Active level after polarity; the pin is already synchronous.
	assign active = ACTIVE_HIGH ? i_pin : ~i_pin;

	// Start inactive so a pin held active at reset still makes an edge.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			prev <= 1'b0;
		else
			prev <= active;
	end

	// An edge needs the pin to go inactive first, so no re-arm early.
	assign o_req = LEVEL_MODE ? active : (active & ~prev);
endmodule

// File: rtl/mcu_interrupt_logic.sv
// Interrupt latch, arbitration, stacking and vector sequencer.
`timescale 1ns/1ps
module mcu_interrupt_logic
#(
	parameter bit EXT_LEVEL_MODE = 1'b1,
	parameter bit PORT_INT_EN = 1'b0,
	parameter bit PORT_LEVEL_MODE = 1'b0
)
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [9:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	input wire logic i_ext_int_n,
	input wire logic [3:0] i_port_int_pins,
	input wire logic i_timer_wrap_flag,
	input wire logic i_periodic_timer_flag,
	input wire logic i_instr_done,
	input wire logic i_soft_trap,
	input wire logic i_return_from_trap,
	input wire logic i_mask_set,
	input wire logic i_mask_clear,
	input wire irq_pkg::cpu_regs_s i_regs,
	input wire logic [7:0] i_stack_rdata,
	output irq_pkg::stack_bus_s o_stack,
	output logic o_vec_fetch,
	output logic [15:0] o_vec_addr,
	output logic o_int_mask,
	output logic o_return_done
);
	// ==========================================================
	// Declarations
	// ==========================================================
	logic rst_n;
	logic ext_pin_req;
	logic [3:0] port_req;
	logic ext_req;
	logic ext_enable;
	logic ext_pending;
	logic wrap_en;
	logic per_en;
	logic timer_req;
	logic ext_ok;
	logic timer_ok;
	logic wb_take;
	logic wb_write;
	logic clear_write;
	logic stacked_i;
	logic cond_read_q;
	logic [2:0] cnt;
	logic [5:0] sp;
	irq_pkg::seq_state_e state;
	irq_pkg::src_e src;
	irq_pkg::src_e next_src;

	// Register selection by word index; upper index bits must be zero.
	function automatic logic is_reg(input logic [9:0] adr,
		input logic [7:0] idx);
		is_reg = (adr[9:2] == idx);
	endfunction

	// Byte pushed for a slot, low program counter byte first.
	function automatic logic [7:0] push_byte(input logic [2:0] n,
		input irq_pkg::cpu_regs_s r);
		case (n)
			irq_pkg::SLOT_PCL: push_byte = r.pc[7:0];
			irq_pkg::SLOT_PCH: push_byte = r.pc[15:8];
			irq_pkg::SLOT_X: push_byte = r.x;
			irq_pkg::SLOT_A: push_byte = r.a;
			default: push_byte = r.cond;
		endcase
	endfunction

	// ==========================================================
	// Reset release
	// ==========================================================
	reset_sync u_reset_sync
	(
		.i_clk(i_mclk),
		.i_rst_n(i_rst_n),
		.o_rst_n(rst_n)
	);

	// ==========================================================
	// Request detection
	// ==========================================================
	// External pin is active low; sensitivity fixed at build time.
	pin_trigger
	#(
		.ACTIVE_HIGH(1'b0),
		.LEVEL_MODE(EXT_LEVEL_MODE)
	)
	u_ext_trig
	(
		.i_clk(i_mclk),
		.i_rst_n(rst_n),
		.i_pin(i_ext_int_n),
		.o_req(ext_pin_req)
	);

	// Port pins are active high and only exist when the option is on.
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_port
			if (PORT_INT_EN)
			begin : g_on
				pin_trigger
				#(
					.ACTIVE_HIGH(1'b1),
					.LEVEL_MODE(PORT_LEVEL_MODE)
				)
				u_port_trig
				(
					.i_clk(i_mclk),
					.i_rst_n(rst_n),
					.i_pin(i_port_int_pins[g]),
					.o_req(port_req[g])
				);
			end
			else
			begin : g_off
				assign port_req[g] = 1'b0;
			end
		end
	endgenerate

	// Every external source feeds one shared latch.
	assign ext_req = ext_pin_req | (|port_req);

	// Timer requests are the flags gated by their enables.
	assign timer_req = (i_timer_wrap_flag & wrap_en)
		| (i_periodic_timer_flag & per_en);

	// ==========================================================
	// Register bus slave
	// ==========================================================
	assign wb_take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	// A write lands on the edge where the master sees ack.
	assign wb_write = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack
		& i_wb_sel[0];
	assign clear_write = wb_write
		& is_reg(i_wb_adr, irq_pkg::EXT_CTRL_IDX)
		& i_wb_dat[irq_pkg::CLEAR_BIT];

	// Ack one cycle after the strobe; unmapped reads return zero.
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end
		else
		begin
			o_wb_ack <= wb_take;
			o_wb_dat <= 32'h0000_0000;
			if (wb_take && is_reg(i_wb_adr, irq_pkg::EXT_CTRL_IDX))
			begin
				// The clear bit is write-only and reads as zero.
				o_wb_dat[irq_pkg::ENABLE_BIT] <= ext_enable;
				o_wb_dat[irq_pkg::PENDING_BIT] <= ext_pending;
			end
			else if (wb_take && is_reg(i_wb_adr, irq_pkg::TCTL_IDX))
			begin
				o_wb_dat[irq_pkg::WRAP_EN_BIT] <= wrap_en;
				o_wb_dat[irq_pkg::PER_EN_BIT] <= per_en;
				o_wb_dat[irq_pkg::WRAP_FLAG_BIT] <= i_timer_wrap_flag;
				o_wb_dat[irq_pkg::PER_FLAG_BIT] <= i_periodic_timer_flag;
				o_wb_dat[irq_pkg::MASK_BIT] <= o_int_mask;
			end
		end
	end

	// Software-written enables.
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_enable <= irq_pkg::ENABLE_RST;
			wrap_en <= irq_pkg::TIMER_EN_RST;
			per_en <= irq_pkg::TIMER_EN_RST;
		end
		else if (wb_write && is_reg(i_wb_adr, irq_pkg::EXT_CTRL_IDX))
			ext_enable <= i_wb_dat[irq_pkg::ENABLE_BIT];
		else if (wb_write && is_reg(i_wb_adr, irq_pkg::TCTL_IDX))
		begin
			wrap_en <= i_wb_dat[irq_pkg::WRAP_EN_BIT];
			per_en <= i_wb_dat[irq_pkg::PER_EN_BIT];
		end
	end

	// ==========================================================
	// External pending latch
	// ==========================================================
	// A new request beats any clear in the same cycle, so a held
	// level keeps the latch set even through the vector fetch.
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			ext_pending <= irq_pkg::PENDING_RST;
		else if (ext_req)
			ext_pending <= 1'b1;
		else if (clear_write)
			ext_pending <= 1'b0;
		else if (state == irq_pkg::S_VECTOR && src == irq_pkg::SRC_EXT)
			ext_pending <= 1'b0;
	end

	// ==========================================================
	// Arbitration
	// ==========================================================
	assign ext_ok = ext_pending & ext_enable & ~o_int_mask;
	assign timer_ok = timer_req & ~o_int_mask;

	// Trap first, then external, then timer.
	always_comb
	begin
		if (i_soft_trap)
			next_src = irq_pkg::SRC_TRAP;
		else if (ext_ok)
			next_src = irq_pkg::SRC_EXT;
		else if (timer_ok)
			next_src = irq_pkg::SRC_TIMER;
		else
			next_src = irq_pkg::SRC_NONE;
	end

	// ==========================================================
	// Sequencer
	// ==========================================================
	// Requests are looked at only at an instruction boundary.
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= irq_pkg::S_IDLE;
			src <= irq_pkg::SRC_NONE;
			cnt <= 3'h0;
		end
		else
		begin
			case (state)
				irq_pkg::S_IDLE:
				begin
					cnt <= 3'h0;
					if (i_instr_done && i_return_from_trap)
						state <= irq_pkg::S_PULL;
					else if (i_instr_done
						&& next_src != irq_pkg::SRC_NONE)
					begin
						state <= irq_pkg::S_PUSH;
						src <= next_src;
					end
				end
				irq_pkg::S_PUSH:
				begin
					cnt <= cnt + 3'h1;
					if (cnt == irq_pkg::STACK_LAST)
						state <= irq_pkg::S_VECTOR;
				end
				irq_pkg::S_VECTOR:
					state <= irq_pkg::S_IDLE;
				irq_pkg::S_PULL:
				begin
					cnt <= cnt + 3'h1;
					if (cnt == irq_pkg::STACK_LAST)
						state <= irq_pkg::S_RESTORE;
				end
				irq_pkg::S_RESTORE:
					state <= irq_pkg::S_IDLE;
				default:
					state <= irq_pkg::S_IDLE;
			endcase
		end
	end

	// Stack traffic: push walks down, pull walks up in reverse slots.
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sp <= irq_pkg::SP_RST;
			o_stack <= '0;
		end
		else
		begin
			o_stack.we <= (state == irq_pkg::S_PUSH);
			o_stack.re <= (state == irq_pkg::S_PULL);
			o_stack.wdata <= 8'h00;
			if (state == irq_pkg::S_PUSH)
			begin
				o_stack.addr <= {irq_pkg::SP_PAGE, sp};
				o_stack.wdata <= push_byte(cnt, i_regs);
				o_stack.slot <= irq_pkg::stack_slot_e'(cnt);
				sp <= sp - 6'h01;
			end
			else if (state == irq_pkg::S_PULL)
			begin
				o_stack.addr <= {irq_pkg::SP_PAGE, sp + 6'h01};
				o_stack.slot <= irq_pkg::stack_slot_e'(
					irq_pkg::STACK_LAST - cnt);
				sp <= sp + 6'h01;
			end
		end
	end

	// The stacked mask bit is caught the cycle after its read shows.
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cond_read_q <= 1'b0;
			stacked_i <= 1'b0;
		end
		else
		begin
			cond_read_q <= o_stack.re
				&& o_stack.slot == irq_pkg::SLOT_COND;
			if (cond_read_q)
				stacked_i <= i_stack_rdata[irq_pkg::COND_MASK_BIT];
		end
	end

	// Global mask: set after the last push, before the vector load.
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			o_int_mask <= irq_pkg::MASK_RST;
		else if (state == irq_pkg::S_PUSH && cnt == irq_pkg::STACK_LAST)
			o_int_mask <= 1'b1;
		else if (state == irq_pkg::S_RESTORE)
			o_int_mask <= stacked_i;
		else if (i_mask_clear)
			o_int_mask <= 1'b0;
		else if (i_mask_set)
			o_int_mask <= 1'b1;
	end

	// Vector address for the source being served.
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_vec_fetch <= 1'b0;
			o_vec_addr <= 16'h0000;
			o_return_done <= 1'b0;
		end
		else
		begin
			o_vec_fetch <= (state == irq_pkg::S_VECTOR);
			o_return_done <= (state == irq_pkg::S_RESTORE);
			if (state == irq_pkg::S_VECTOR)
			begin
				case (src)
					irq_pkg::SRC_TRAP: o_vec_addr <= irq_pkg::VEC_TRAP;
					irq_pkg::SRC_EXT: o_vec_addr <= irq_pkg::VEC_EXT;
					default: o_vec_addr <= irq_pkg::VEC_TIMER;
				endcase
			end
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!rst_n);

	sequence push_run;
		(state == irq_pkg::S_PUSH)[*5];
	endsequence
	sequence vector_step;
		state == irq_pkg::S_VECTOR ##1 o_vec_fetch;
	endsequence

	a_pend_sets:
	assert property (ext_req |=> ext_pending)
		else $error("request did not set pending latch");
	a_ext_accept:
	assert property (state == irq_pkg::S_IDLE && i_instr_done
		&& !i_return_from_trap && !i_soft_trap && ext_ok
		|=> state == irq_pkg::S_PUSH && src == irq_pkg::SRC_EXT)
		else $error("eligible external request not accepted");
	a_vec_clears:
	assert property (state == irq_pkg::S_VECTOR
		&& src == irq_pkg::SRC_EXT && !ext_req && !clear_write
		|=> !ext_pending)
		else $error("vector fetch left pending latch set");
	a_clear_bit:
	assert property (clear_write && !ext_req |=> !ext_pending)
		else $error("clear bit write did not clear pending");
	a_mask_blocks:
	assert property (state == irq_pkg::S_IDLE && o_int_mask
		&& !i_soft_trap |=> state != irq_pkg::S_PUSH)
		else $error("masked request was accepted");
	a_trap_always:
	assert property (state == irq_pkg::S_IDLE && i_instr_done
		&& i_soft_trap |=> src == irq_pkg::SRC_TRAP)
		else $error("soft trap not taken");
	a_push_five:
	assert property ($rose(state == irq_pkg::S_PUSH)
		|-> push_run ##1 vector_step)
		else $error("push did not take five bytes");
	a_mask_at_vec:
	assert property (state == irq_pkg::S_VECTOR |-> o_int_mask
		&& $past(o_stack.we))
		else $error("mask not set before vector");
	a_ext_vector:
	assert property (state == irq_pkg::S_VECTOR
		&& src == irq_pkg::SRC_EXT |=> o_vec_addr == irq_pkg::VEC_EXT)
		else $error("wrong external vector");
	a_ext_priority:
	assert property (state == irq_pkg::S_IDLE && i_instr_done
		&& !i_soft_trap && !i_return_from_trap && ext_ok && timer_ok
		|=> src == irq_pkg::SRC_EXT)
		else $error("timer beat external request");
endmodule

// File: testbench/int_source.sv
// Model of the outside sources that drive the interrupt pins.
`timescale 1ns/1ps
module int_source
(
	input wire logic i_clk,
	input wire logic i_ext_active,
	input wire logic [3:0] i_port_active,
	output logic o_ext_int_n,
	output logic [3:0] o_port_int_pins
);
	// ==========================================================
	// Pin drivers
	// ==========================================================
	// The external line has a pull-up, so it idles high; ports idle low.
	initial
	begin
		o_ext_int_n = 1'b1;
		o_port_int_pins = 4'h0;
	end
	// Pins move just after an edge, so the block never sees a half step.
	always @(posedge i_clk)
	begin
		o_ext_int_n <= ~i_ext_active;
		o_port_int_pins <= i_port_active;
	end
endmodule

// File: testbench/mcu_interrupt_logic_tb.sv
// Self-checking bench for the interrupt latch, registers and sequencer.
`timescale 1ns/1ps
module mcu_interrupt_logic_tb;
	// ==========================================================
	// Stimulus and observed signals
	// ==========================================================
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic ack, vf, imask, rdone, ext_n;
	logic [31:0] rdat;
	logic [15:0] vaddr;
	logic ext_act = 1'b0;
	logic [3:0] port_act = 4'h0;
	logic [3:0] port_pins;
	logic wrap = 1'b0, per = 1'b0, done = 1'b0, trap = 1'b0;
	logic ret = 1'b0, mset = 1'b0, mclr = 1'b0;
	logic [7:0] srd = 8'h00;
	logic [7:0] sp = 8'hff;
	irq_pkg::cpu_regs_s regs = '{16'h1234, 8'h56, 8'h78, 8'he0};
	irq_pkg::stack_bus_s stk;
	logic [31:0] lvl_rdat;
	logic [31:0] lvl_dat = 32'h0;
	int n_mismatch = 0, cmp_count = 0, cycles = 0;

	// Edge-only pins with the port sources fitted.
	mcu_interrupt_logic #(.EXT_LEVEL_MODE(1'b0), .PORT_INT_EN(1'b1),
		.PORT_LEVEL_MODE(1'b0)) u_dut (.i_mclk(i_mclk),
		.i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_ack(ack),
		.o_wb_dat(rdat), .i_ext_int_n(ext_n), .i_port_int_pins(port_pins),
		.i_timer_wrap_flag(wrap), .i_periodic_timer_flag(per),
		.i_instr_done(done), .i_soft_trap(trap), .i_return_from_trap(ret),
		.i_mask_set(mset), .i_mask_clear(mclr), .i_regs(regs),
		.i_stack_rdata(srd), .o_stack(stk), .o_vec_fetch(vf),
		.o_vec_addr(vaddr), .o_int_mask(imask), .o_return_done(rdone));
	int_source u_src (.i_clk(i_mclk), .i_ext_active(ext_act),
		.i_port_active(port_act), .o_ext_int_n(ext_n),
		.o_port_int_pins(port_pins));
	// Level-sensitive twin on the same inputs. Only its register reads
	// are compared: a held pin makes its sequencer take extra requests.
	mcu_interrupt_logic #(.EXT_LEVEL_MODE(1'b1), .PORT_INT_EN(1'b1),
		.PORT_LEVEL_MODE(1'b1)) u_lvl (.i_mclk(i_mclk),
		.i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_ack(),
		.o_wb_dat(lvl_rdat), .i_ext_int_n(ext_n),
		.i_port_int_pins(port_pins), .i_timer_wrap_flag(wrap),
		.i_periodic_timer_flag(per), .i_instr_done(done),
		.i_soft_trap(trap), .i_return_from_trap(ret), .i_mask_set(mset),
		.i_mask_clear(mclr), .i_regs(regs), .i_stack_rdata(srd),
		.o_stack(), .o_vec_fetch(), .o_vec_addr(), .o_int_mask(),
		.o_return_done());

	// ==========================================================
	// Clock, timeout and shared tasks
	// ==========================================================
	// Free-running 100 MHz clock.
	initial
	begin
		forever #5 i_mclk = ~i_mclk;
	end
	// The whole run needs well under a thousand cycles.
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: run took too long", $time);
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("Compared %0d, mismatched %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// Classic cycle: the request stands until ack is seen at a rising
	// edge; read data is taken at that edge and only then released.
	// No wait limit here, the cycle timeout ends a hung bus.
	task automatic wb_cycle(input logic w, input logic [9:0] a,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge i_mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		sel <= 4'h1;
		do
			@(posedge i_mclk);
		while (ack !== 1'b1);
		q = rdat;
		lvl_dat = lvl_rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		logic [31:0] q;
		wb_cycle(1'b0, a, 8'h00, q);
		check(q, {24'h0, e});
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb_cycle(1'b1, a, d, q);
	endtask
	task automatic unmask();
		@(posedge i_mclk);
		mclr <= 1'b1;
		@(posedge i_mclk);
		mclr <= 1'b0;
	endtask
	function automatic logic [7:0] slot_byte(input int s);
		case (s)
			0: return regs.pc[7:0];
			1: return regs.pc[15:8];
			2: return regs.x;
			3: return regs.a;
			default: return regs.cond;
		endcase
	endfunction
	// One instruction boundary; watches the push and the vector fetch.
	task automatic service(input logic t, input logic fire,
		input logic [15:0] vec);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		@(posedge i_mclk);
		done <= 1'b1;
		trap <= t;
		@(posedge i_mclk);
		done <= 1'b0;
		trap <= 1'b0;
		repeat (14)
		begin
			@(negedge i_mclk);
			if (stk.we === 1'b1)
			begin
				check(stk.addr, sp);
				check(stk.slot, n);
				check(stk.wdata, slot_byte(n));
				sp--;
				n++;
			end
			if (vf === 1'b1)
			begin
				got = 1'b1;
				check(vaddr, vec);
				check(imask, 1'b1);
			end
		end
		check(got, fire);
		check(n, fire ? 5 : 0);
	endtask
	// Stack data answers one cycle after each read strobe.
	task automatic do_return();
		int n;
		logic [7:0] pend;
		logic got;
		n = 0;
		pend = 8'h00;
		got = 1'b0;
		@(posedge i_mclk);
		done <= 1'b1;
		ret <= 1'b1;
		@(posedge i_mclk);
		done <= 1'b0;
		ret <= 1'b0;
		repeat (14)
		begin
			@(negedge i_mclk);
			if (stk.re === 1'b1)
			begin
				sp++;
				check(stk.addr, sp);
				check(stk.slot, 4 - n);
				pend = slot_byte(4 - n);
				n++;
			end
			if (rdone === 1'b1)
				got = 1'b1;
			@(posedge i_mclk);
			srd <= pend;
		end
		check(got, 1'b1);
		check(n, 5);
		check(imask, 1'b0);
	endtask

	// ==========================================================
	// Test sequence
	// ==========================================================
	initial
	begin
		idle(8);
		i_rst_n <= 1'b1;
		idle(3);
		rd(10'h028, 8'h80);
		rd(10'h02c, 8'h80);
		rd(10'h03c, 8'h00);
		ext_act <= 1'b1;
		idle(4);
		rd(10'h028, 8'h88);
		wr(10'h028, 8'h80);
		rd(10'h028, 8'h88);
		wr(10'h028, 8'h82);
		rd(10'h028, 8'h80);
		check(lvl_dat, 32'h0000_0088);
		idle(4);
		rd(10'h028, 8'h80);
		wr(10'h028, 8'h08);
		rd(10'h028, 8'h00);
		ext_act <= 1'b0;
		idle(3);
		ext_act <= 1'b1;
		idle(4);
		rd(10'h028, 8'h08);
		wr(10'h028, 8'h88);
		service(1'b0, 1'b0, 16'h0000);
		wr(10'h028, 8'h08);
		unmask();
		service(1'b0, 1'b0, 16'h0000);
		wr(10'h028, 8'h80);
		rd(10'h028, 8'h88);
		service(1'b0, 1'b1, 16'h07fa);
		rd(10'h028, 8'h80);
		do_return();
		ext_act <= 1'b0;
		port_act <= 4'h4;
		idle(4);
		rd(10'h028, 8'h88);
		wr(10'h028, 8'h82);
		idle(4);
		rd(10'h028, 8'h80);
		check(lvl_dat, 32'h0000_0088);
		wr(10'h02c, 8'h01);
		wrap <= 1'b1;
		port_act <= 4'h1;
		idle(4);
		service(1'b0, 1'b1, 16'h07fa);
		service(1'b0, 1'b0, 16'h0000);
		unmask();
		service(1'b0, 1'b1, 16'h07f8);
		wr(10'h02c, 8'h02);
		wrap <= 1'b0;
		per <= 1'b1;
		unmask();
		service(1'b0, 1'b1, 16'h07f8);
		rd(10'h02c, 8'ha2);
		wr(10'h028, 8'h00);
		service(1'b1, 1'b1, 16'h07fc);
		give_verdict();
	end
endmodule
